// ### logic/ebc_pkg.sv
// package of constants for the byte-wide nonvolatile data memory controller
package ebc_pkg;

  // memory geometry
  localparam int MEM_BYTES_LARGE = 512;
  localparam int MEM_BYTES_SMALL = 256;

  // apb byte offsets of the register words
  localparam logic [3:0] OFS_CONTROL   = 4'h0;
  localparam logic [3:0] OFS_ADDR_LOW  = 4'h4;
  localparam logic [3:0] OFS_ADDR_HIGH = 4'h8;
  localparam logic [3:0] OFS_DATA      = 4'hc;

  // control register bit positions
  localparam int BIT_READ_STROBE  = 0;
  localparam int BIT_PROG_ENABLE  = 1;
  localparam int BIT_MASTER_EN    = 2;
  localparam int BIT_READY_IRQ_EN = 3;
  localparam int BIT_MODE_LO      = 4;
  localparam int BIT_MODE_HI      = 5;

  // programming mode field codes
  localparam logic [1:0] MODE_ATOMIC   = 2'h0;
  localparam logic [1:0] MODE_ERASE    = 2'h1;
  localparam logic [1:0] MODE_WRITE    = 2'h2;
  localparam logic [1:0] MODE_RESERVED = 2'h3;

  // reset values, and the value of an erased byte
  localparam logic [1:0] MODE_RESET  = MODE_ATOMIC;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam logic [7:0] BYTE_ZERO   = 8'h00;

  // cpu clock cycle counts
  localparam logic [2:0] MPE_WINDOW  = 3'h4;
  localparam logic [2:0] READ_HALT   = 3'h4;
  localparam logic [2:0] PROG_HALT   = 3'h2;
  localparam logic [2:0] COUNT_ZERO  = 3'h0;
  localparam logic [2:0] COUNT_ONE   = 3'h1;

  // programming times, counted on the internal oscillator
  localparam real OSC_FREQ_MHZ = 8.0;
  localparam real T_ATOMIC_MS  = 3.4;
  localparam real T_SPLIT_MS   = 1.8;
  localparam int  ATOMIC_TICKS = int'(T_ATOMIC_MS * 1000.0 * OSC_FREQ_MHZ);
  localparam int  SPLIT_TICKS  = int'(T_SPLIT_MS * 1000.0 * OSC_FREQ_MHZ);
  localparam int  TICK_CNT_W   = 15;

endpackage

// ### logic/ebc_prog_timer.sv
// programming duration timer on the cpu clock counting oscillator ticks, survives reset while busy
`timescale 1ns/100ps
module ebc_prog_timer #(
  parameter int ATOMIC_TICKS = ebc_pkg::ATOMIC_TICKS,
  parameter int SPLIT_TICKS  = ebc_pkg::SPLIT_TICKS,
  parameter int CNT_W        = ebc_pkg::TICK_CNT_W
) (
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             resetn,
  // control
  input  wire logic             start,
  input  wire logic [1:0]       mode,
  input  wire logic             osc_tick,
  // status
  output logic                  busy,
  output logic                  done
);

  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] load_value;

  // erase-and-write takes the long count, either half alone the short one
  always_comb begin
    if (mode == ebc_pkg::MODE_ATOMIC) begin
      load_value = CNT_W'(ATOMIC_TICKS);
    end else begin
      load_value = CNT_W'(SPLIT_TICKS);
    end
  end

  // countdown on oscillator ticks only, so cpu clock rate does not matter
  always_ff @(posedge clk_sys) begin
    if (start) begin
      count <= load_value;
      busy  <= 1'b1;
    end else if (busy && osc_tick) begin
      if (count == CNT_W'(1)) begin
        count <= '0;
        busy  <= 1'b0;
      end else begin
        count <= count - CNT_W'(1);
      end
    end else if (!resetn) begin
      // reset only reaches an idle timer: a running one finishes;
      // a flag that is still unknown at power-up takes the clearing branch
      if (busy) begin
        busy <= 1'b1;
      end else begin
        count <= '0;
        busy  <= 1'b0;
      end
    end
  end

  // one cycle completion pulse
  always_ff @(posedge clk_sys) begin
    if (!resetn && !busy) begin
      done <= 1'b0;
    end else begin
      done <= busy && osc_tick && (count == CNT_W'(1));
    end
  end

endmodule

// ### logic/ebc_top.sv
// byte-wide nonvolatile data memory controller with apb register access
//
// Decided for this implementation: the placing of the registers and the APB slave port.
`timescale 1ns/100ps
module ebc_top #(
  parameter int MEM_BYTES    = ebc_pkg::MEM_BYTES_LARGE,
  parameter int ADDR_W       = $clog2(MEM_BYTES),
  parameter int PADDR_W      = 12,
  parameter int ATOMIC_TICKS = ebc_pkg::ATOMIC_TICKS,
  parameter int SPLIT_TICKS  = ebc_pkg::SPLIT_TICKS
) (
  // clock and reset
  input  wire logic               clk_sys,
  input  wire logic               resetn,
  // apb slave
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [PADDR_W-1:0] paddr,
  input  wire logic [31:0]        pwdata,
  input  wire logic [3:0]         pstrb,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  // internal oscillator tick, one pulse per oscillator period
  input  wire logic               osc_tick,
  // core side
  output logic                    cpu_halt,
  output logic                    ready_irq
);

  // register state
  logic [1:0]        prog_mode_field;
  logic              ready_irq_enable;
  logic [2:0]        mpe_count;
  logic [ADDR_W-1:0] nvm_addr_reg;
  logic [7:0]        nvm_data_reg;
  logic [2:0]        halt_count;

  // latched operation, held for the whole programming time
  logic [ADDR_W-1:0] op_addr;
  logic [7:0]        op_data;
  logic [1:0]        op_mode;

  // storage array
  logic [7:0]        mem [MEM_BYTES];

  // timer status
  logic              program_enable_busy;
  logic              prog_done;

  // bus decode
  logic              access_cycle;
  logic              commit;
  logic              unmapped;
  logic [3:0]        reg_ofs;
  logic              wr_commit;
  logic [7:0]        wbyte;
  logic              ctrl_wr;
  logic              addr_low_wr;
  logic              addr_high_wr;
  logic              data_wr;

  // derived control
  logic              master_program_enable;
  logic              prog_request;
  logic              read_request;
  logic              arm_request;
  logic              array_idle;
  logic              mode_legal;
  logic              mode_wr;
  logic              start_prog;
  logic              start_read;
  logic [15:0]       addr_wide;
  logic [15:0]       next_addr_wide;
  logic [2:0]        next_halt_count;
  logic [2:0]        next_mpe_count;
  logic [7:0]        read_byte;
  logic [7:0]        control_view;
  logic [31:0]       next_prdata;
  logic              next_pready;
  logic              next_pslverr;
  logic              next_cpu_halt;
  logic              next_ready_irq;
  logic [7:0]        next_mem_byte;

  // apb decode; only the low byte lane carries register data
  assign access_cycle = psel && penable && !pready;
  assign commit       = psel && penable && pready;
  assign reg_ofs      = paddr[3:0];
  assign unmapped     = (paddr[PADDR_W-1:4] != '0) || (paddr[1:0] != 2'h0);
  assign wr_commit    = commit && pwrite && !unmapped && pstrb[0];
  assign wbyte        = pwdata[7:0];
  assign ctrl_wr      = wr_commit && (reg_ofs == ebc_pkg::OFS_CONTROL);
  assign addr_low_wr  = wr_commit && (reg_ofs == ebc_pkg::OFS_ADDR_LOW);
  assign addr_high_wr = wr_commit && (reg_ofs == ebc_pkg::OFS_ADDR_HIGH);
  assign data_wr      = wr_commit && (reg_ofs == ebc_pkg::OFS_DATA);

  // master enable is live only while its window counter runs
  assign master_program_enable = (mpe_count != ebc_pkg::COUNT_ZERO);

  // raw requests carried by a control write, before any qualification
  assign prog_request = ctrl_wr && wbyte[ebc_pkg::BIT_PROG_ENABLE];
  assign read_request = ctrl_wr && wbyte[ebc_pkg::BIT_READ_STROBE];
  assign arm_request  = ctrl_wr && wbyte[ebc_pkg::BIT_MASTER_EN];

  // the array takes new work only while no programming runs
  assign array_idle = !program_enable_busy;

  // reserved mode code starts no programming and leaves the window open
  assign mode_legal = (prog_mode_field != ebc_pkg::MODE_RESERVED);

  // programming needs an armed master enable, an idle array and a legal mode
  assign start_prog = prog_request
                      && master_program_enable
                      && array_idle
                      && mode_legal;

  // a read strobe during programming is dropped; programming wins a tie
  assign start_read = read_request && array_idle && !start_prog;

  // mode field writes are dropped while the array is busy
  assign mode_wr = ctrl_wr && array_idle;

  // address zero-extended so both sizes share one byte-lane layout
  assign addr_wide = 16'(nvm_addr_reg);

  // array read port, one byte per access
  assign read_byte = mem[nvm_addr_reg];

  // control view: read strobe reads back zero, reserved bits zero
  always_comb begin
    control_view = ebc_pkg::BYTE_ZERO;
    control_view[ebc_pkg::BIT_MODE_HI:ebc_pkg::BIT_MODE_LO] = prog_mode_field;
    control_view[ebc_pkg::BIT_READY_IRQ_EN] = ready_irq_enable;
    control_view[ebc_pkg::BIT_MASTER_EN]    = master_program_enable;
    control_view[ebc_pkg::BIT_PROG_ENABLE]  = program_enable_busy;
  end

  // address update; bits above the array size are dropped
  always_comb begin
    next_addr_wide = addr_wide;
    if (addr_low_wr) begin
      next_addr_wide[7:0] = wbyte;
    end
    if (addr_high_wr) begin
      next_addr_wide[15:8] = wbyte;
    end
  end

  // master enable window: four cpu cycles from arming, spent by a start
  always_comb begin
    if (start_prog) begin
      next_mpe_count = ebc_pkg::COUNT_ZERO;
    end else if (arm_request) begin
      next_mpe_count = ebc_pkg::MPE_WINDOW;
    end else if (master_program_enable) begin
      next_mpe_count = mpe_count - ebc_pkg::COUNT_ONE;
    end else begin
      next_mpe_count = ebc_pkg::COUNT_ZERO;
    end
  end

  // cpu halt length depends on what was started
  always_comb begin
    if (start_read) begin
      next_halt_count = ebc_pkg::READ_HALT;
    end else if (start_prog) begin
      next_halt_count = ebc_pkg::PROG_HALT;
    end else if (halt_count != ebc_pkg::COUNT_ZERO) begin
      next_halt_count = halt_count - ebc_pkg::COUNT_ONE;
    end else begin
      next_halt_count = ebc_pkg::COUNT_ZERO;
    end
  end

  // read data selection for the bus
  always_comb begin
    next_prdata = 32'h0000_0000;
    if (!unmapped) begin
      unique case (reg_ofs)
        ebc_pkg::OFS_CONTROL:   next_prdata[7:0] = control_view;
        ebc_pkg::OFS_ADDR_LOW:  next_prdata[7:0] = addr_wide[7:0];
        ebc_pkg::OFS_ADDR_HIGH: next_prdata[7:0] = addr_wide[15:8];
        ebc_pkg::OFS_DATA:      next_prdata[7:0] = nvm_data_reg;
        default:                next_prdata = 32'h0000_0000;
      endcase
    end
  end

  // response for the next edge: a single wait state, error for holes in the map
  assign next_pready  = access_cycle;
  assign next_pslverr = access_cycle && unmapped;

  // apb handshake: one wait state so all answers come from flops
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= next_pready;
      pslverr <= next_pslverr;
      if (access_cycle) begin
        prdata <= next_prdata;
      end
    end
  end

  // mode field: frozen while programming, and reset does not touch it then
  always_ff @(posedge clk_sys) begin
    if (!resetn && !program_enable_busy) begin
      prog_mode_field <= ebc_pkg::MODE_RESET;
    end else if (mode_wr) begin
      prog_mode_field <= wbyte[ebc_pkg::BIT_MODE_HI:ebc_pkg::BIT_MODE_LO];
    end
  end

  // ready interrupt enable
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      ready_irq_enable <= 1'b0;
    end else if (ctrl_wr) begin
      ready_irq_enable <= wbyte[ebc_pkg::BIT_READY_IRQ_EN];
    end
  end

  // master enable window counter
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      mpe_count <= ebc_pkg::COUNT_ZERO;
    end else begin
      mpe_count <= next_mpe_count;
    end
  end

  // address register: writes cannot change it while programming, but reset still clears it
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      nvm_addr_reg <= '0;
    end else if (array_idle) begin
      nvm_addr_reg <= next_addr_wide[ADDR_W-1:0];
    end
  end

  // data register: software load, or the byte fetched by a read strobe
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      nvm_data_reg <= ebc_pkg::BYTE_ZERO;
    end else if (start_read) begin
      nvm_data_reg <= read_byte;
    end else if (data_wr) begin
      nvm_data_reg <= wbyte;
    end
  end

  // operation latch; not reset so a running operation keeps its target
  always_ff @(posedge clk_sys) begin
    if (start_prog) begin
      op_addr <= nvm_addr_reg;
      op_data <= nvm_data_reg;
      op_mode <= prog_mode_field;
    end
  end

  // next array byte for the latched operation
  always_comb begin
    unique case (op_mode)
      // erase then write in one go: new value stands as given
      ebc_pkg::MODE_ATOMIC: next_mem_byte = op_data;
      // erase only: all ones
      ebc_pkg::MODE_ERASE:  next_mem_byte = ebc_pkg::ERASED_BYTE;
      // write only can just clear bits, so an unerased byte ends corrupted
      ebc_pkg::MODE_WRITE:  next_mem_byte = mem[op_addr] & op_data;
      default:              next_mem_byte = mem[op_addr];
    endcase
  end

  // array update at the end of the programming time
  always_ff @(posedge clk_sys) begin
    if (prog_done) begin
      mem[op_addr] <= next_mem_byte;
    end
  end

  // halt stays up while any stall cycle is still to come
  assign next_cpu_halt = (next_halt_count != ebc_pkg::COUNT_ZERO);

  // cpu halt counter and its registered output
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      halt_count <= ebc_pkg::COUNT_ZERO;
      cpu_halt   <= 1'b0;
    end else begin
      halt_count <= next_halt_count;
      cpu_halt   <= next_cpu_halt;
    end
  end

  // ready level drops at the edge a start is taken, not one later
  assign next_ready_irq = ready_irq_enable && array_idle && !start_prog;

  // ready interrupt is a level: idle array with the enable set
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      ready_irq <= 1'b0;
    end else begin
      ready_irq <= next_ready_irq;
    end
  end

  // duration timer; busy flag doubles as the program enable bit
  ebc_prog_timer #(
    .ATOMIC_TICKS (ATOMIC_TICKS),
    .SPLIT_TICKS  (SPLIT_TICKS),
    .CNT_W        (ebc_pkg::TICK_CNT_W)
  ) u_timer (
    .clk_sys  (clk_sys),
    .resetn   (resetn),
    .start    (start_prog),
    .mode     (prog_mode_field),
    .osc_tick (osc_tick),
    .busy     (program_enable_busy),
    .done     (prog_done)
  );

endmodule

// ### test/ebc_top_properties.sv
// port checker for the nonvolatile memory controller
`timescale 1ns/100ps
module ebc_top_properties #(
  parameter int PADDR_W = 12
) (
  // clock and reset
  input wire logic               clk_sys,
  input wire logic               resetn,
  // apb slave
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic [PADDR_W-1:0] paddr,
  input wire logic [31:0]        pwdata,
  input wire logic [3:0]         pstrb,
  input wire logic [31:0]        prdata,
  input wire logic               pready,
  input wire logic               pslverr,
  // core side
  input wire logic               cpu_halt,
  input wire logic               ready_irq
);
  // committed control write, read strobe alone, program start alone
  wire logic cw = psel & penable & pready & pwrite & pstrb[0] & (paddr == PADDR_W'(ebc_pkg::OFS_CONTROL));
  wire logic rs = cw & pwdata[0] & ~pwdata[1];
  wire logic ps = cw & pwdata[1] & ~pwdata[0];
  wire logic rd = pready & ~pwrite & ~pslverr;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  property p_wait; psel & $rose(penable) |-> !pready ##1 pready; endproperty
  a_wait: assert property (p_wait) else $error("answer not after one wait state");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
  property p_err; pready |-> pslverr == (paddr[1:0] != 2'h0 || paddr > PADDR_W'(12)); endproperty
  a_err: assert property (p_err) else $error("wrong error answer");
  property p_byte; pready & ~pwrite |-> prdata[31:8] == 24'h0; endproperty
  a_byte: assert property (p_byte) else $error("read wider than a byte");
  property p_ahigh; rd & paddr == PADDR_W'(8) |-> prdata[7:1] == 7'h0; endproperty
  a_ahigh: assert property (p_ahigh) else $error("unused address bits not zero");
  property p_ctl; rd & paddr == PADDR_W'(0) |-> prdata[7:6] == 2'h0 && !prdata[0]; endproperty
  a_ctl: assert property (p_ctl) else $error("control reserved bits set");
  property p_rhalt; $rose(cpu_halt) && ($past(rs) || $past(rs, 2)) |-> cpu_halt[*4] ##1 !cpu_halt; endproperty
  a_rhalt: assert property (p_rhalt) else $error("read stall not four cycles");
  property p_phalt; $rose(cpu_halt) && ($past(ps) || $past(ps, 2)) |-> cpu_halt[*2] ##1 !cpu_halt; endproperty
  a_phalt: assert property (p_phalt) else $error("program stall not two cycles");
  property p_cause; $rose(cpu_halt) |-> $past(cw) || $past(cw, 2); endproperty
  a_cause: assert property (p_cause) else $error("stall without a control write");
  property p_irq; rd & paddr == PADDR_W'(0) & prdata[1] |-> !ready_irq; endproperty
  a_irq: assert property (p_irq) else $error("ready interrupt while busy");
  // main scenarios reached
  c_prog: cover property (ps);
  c_irq: cover property ($rose(ready_irq));
  c_err: cover property (pready & pslverr);
endmodule

// ### test/tb_ebc_top.sv
// self-checking bench for the nonvolatile memory controller
`timescale 1ns/100ps
module tb_ebc_top;
  localparam int AT = 20;
  localparam int ST = 10;
  logic        clk_sys, resetn, psel, penable, pwrite, osc_tick, pready, pslverr, cpu_halt, ready_irq;
  logic        err, cnt_on, irq_low, osc_tick_q;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  logic [3:0]  pstrb;
  logic [8:0]  a;
  logic [7:0]  d;
  logic [1:0]  m;
  logic [7:0]  mem [512];
  int          miscompares, n_compared, cyc, ticks, seed;

  // clock, 50 ns period
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  ebc_top #(.MEM_BYTES(512), .ATOMIC_TICKS(AT), .SPLIT_TICKS(ST)) u_ebc_top (
    .clk_sys(clk_sys), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .osc_tick(osc_tick), .cpu_halt(cpu_halt), .ready_irq(ready_irq));

  // two ticks in five clocks gives 8 against 20 mhz; also counts ticks until ready returns,
  // one edge late so the count lines up with the edges at which the timer runs
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    osc_tick <= (cyc % 5 == 0) || (cyc % 5 == 2);
    osc_tick_q <= osc_tick;
    if (cnt_on) begin
      ticks <= ticks + int'(osc_tick_q);
      irq_low <= irq_low | ~ready_irq;
      if (ready_irq & irq_low) cnt_on <= 1'b0;
    end
    if (cyc == 20000) begin
      miscompares = miscompares + 1;
      wrap_up();
    end
  end

  task automatic wrap_up;
    if (miscompares == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared = n_compared + 1;
    if (seen !== exp) begin
      miscompares = miscompares + 1;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one apb transfer; ends one edge after the answer so calls never collide
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] wd, input logic [3:0] s);
    int n;
    psel <= 1'b1; pwrite <= w; paddr <= ad; pwdata <= wd; pstrb <= s;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1);
    chk(32'(n), 32'h2);
    rv = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic wr(input logic [11:0] ad, input logic [31:0] wd);
    apb(1'b1, ad, wd, 4'hf);
  endtask

  task automatic rd(input logic [11:0] ad, input logic [31:0] exp);
    apb(1'b0, ad, 32'h0, 4'hf);
    chk(rv, exp);
  endtask

  task automatic idle;
    do apb(1'b0, 12'h0, 32'h0, 4'hf); while (rv[1] !== 1'b0 && cyc < 20000);
  endtask

  // erase gives all ones, write-only can only clear bits, atomic stores the byte
  function automatic logic [7:0] exp_byte(input logic [1:0] md, input logic [7:0] o, input logic [7:0] dd);
    if (md == ebc_pkg::MODE_ERASE) return ebc_pkg::ERASED_BYTE;
    if (md == ebc_pkg::MODE_WRITE) return o & dd;
    return dd;
  endfunction

  // program start lands at the last edge of the master window
  task automatic prog(input logic [1:0] md, input logic [8:0] ad, input logic [7:0] dd);
    idle();
    wr(12'h0, {26'h0, md, 4'h8});
    wr(12'h4, {24'h0, ad[7:0]});
    wr(12'h8, {31'h0, ad[8]});
    wr(12'hc, {24'h0, dd});
    wr(12'h0, {26'h0, md, 4'hc});
    wr(12'h0, {26'h0, md, 4'ha});
    ticks <= 0; irq_low <= 1'b0; cnt_on <= 1'b1;
    mem[ad] = exp_byte(md, mem[ad], dd);
  endtask

  task automatic readback(input logic [8:0] ad);
    idle();
    wr(12'h4, {24'h0, ad[7:0]});
    wr(12'h8, {31'h0, ad[8]});
    wr(12'h0, 32'h9);
    rd(12'hc, {24'h0, mem[ad]});
  endtask

  initial begin
    seed = 32'hb93ff444;
    {resetn, psel, penable, pwrite, osc_tick, cnt_on, irq_low} = '0;
    paddr = 12'h0; pwdata = 32'h0; pstrb = 4'h0;
    {cyc, ticks, miscompares, n_compared} = '0;
    repeat (12) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    rd(12'h0, 32'h0);
    chk({31'h0, ready_irq}, 32'h0);
    for (int i = 0; i < 2; i++) begin
      apb(1'b0, i ? 12'h006 : 12'h010, 32'h0, 4'hf);
      chk({31'h0, err}, 32'h1);
    end
    wr(12'h8, 32'hff);
    rd(12'h8, 32'h1);
    apb(1'b1, 12'h4, 32'h5a, 4'he);
    rd(12'h4, 32'h0);
    for (int i = 0; i < 9; i++) begin
      if (i % 3 == 0) a = (i == 6) ? 9'h1ff : (i == 0) ? 9'h000 : 9'($random(seed));
      d = 8'($random(seed));
      m = (i % 3 == 0) ? ebc_pkg::MODE_ERASE : (i % 3 == 1) ? ebc_pkg::MODE_WRITE : ebc_pkg::MODE_ATOMIC;
      prog(m, a, d);
      wr(12'h4, {24'h0, ~a[7:0]});
      wr(12'h0, 32'h39);
      rd(12'h0, {26'h0, m, 4'ha});
      while (cnt_on && cyc < 20000) @(posedge clk_sys);
      chk(32'(ticks >= (m == 2'h0 ? AT : ST) && ticks <= (m == 2'h0 ? AT : ST) + 3), 32'h1);
      readback(a);
    end
    // window runs out one edge too early for the start
    wr(12'h0, 32'hc);
    @(posedge clk_sys);
    wr(12'h0, 32'ha);
    rd(12'h0, 32'h8);
    wr(12'h0, 32'h3c);
    wr(12'h0, 32'h3a);
    rd(12'h0, 32'h38);
    a = 9'($random(seed));
    d = 8'($random(seed));
    prog(ebc_pkg::MODE_ERASE, a, d);
    resetn <= 1'b0;
    repeat (3) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    rd(12'h0, 32'h12);
    readback(a);
    wrap_up();
  end
endmodule

bind ebc_top ebc_top_properties #(.PADDR_W(PADDR_W)) u_ebc_top_properties (
  .clk_sys(clk_sys), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .cpu_halt(cpu_halt), .ready_irq(ready_irq));
